/* File: design/cpc_converter.sv */
`timescale 1ns/10ps
// Function
// - Accept 18-bit legacy I and Q samples
// - Truncated 18-bit phase, 16 MSBs to formatter
// - Phase gain one over two pi
// - Phase MSB weighs 180 degrees, halving
// - Unsigned magnitude, bit 13 weight one
// - Magnitude MSB always reads zero
// - Seventeen iterations then latch results
// - Early sample latches partial result, restarts
// - Accuracy improves with each iteration
// - Optional direct 26-bit FIR input routing
// - Direct routing bypasses gain stage entirely
// - Route bit selects FIR or legacy source
// - Q-zero bit forces Q input to zero
// - Capture strobe chosen by resampler bypass
// - Discriminator still gets 18 phase MSBs
module cpc_converter
    import cpc_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rstn,
    input  wire logic              clockEnable,
    input  wire cpc_leg_type       legacySample,     // Gain-scaled or resampled I/Q
    input  wire cpc_fir_type       firSample,        // Full-width FIR I/Q
    input  wire logic              gainReady,        // Gain stage data-ready strobe
    input  wire logic              resamplerReady,   // Resampler data-ready strobe
    input  wire logic              resamplerBypass,  // High when the resampler is bypassed
    input  wire logic              firRouteSel,      // One selects direct FIR routing
    input  wire logic              qZero,            // One zeroes the Q input
    output cpc_res_type            result,           // Latched magnitude and phase
    output logic                   resultReady       // Strobe for one enabled cycle on each latch
);

    // ==========================================================
    // Input selection
    logic                 sampleStrobe;   // Capture strobe
    logic [FIR_W-1:0]     srcI;           // Selected I at FIR scale
    logic [FIR_W-1:0]     srcQ;           // Selected Q at FIR scale
    logic [FIR_W-1:0]     legI;           // Legacy I, left-aligned
    logic [FIR_W-1:0]     legQ;           // Legacy Q, left-aligned

    // Strobe follows the gain stage only when the resampler is out of the path
    assign sampleStrobe = resamplerBypass ? gainReady : resamplerReady;
    // Legacy samples are scaled up so both sources share one output scale
    assign legI = {legacySample.i, {LEG_SHIFT{1'b0}}};
    assign legQ = {legacySample.q, {LEG_SHIFT{1'b0}}};
    // Direct FIR routing never passes through gain scaling
    assign srcI = firRouteSel ? firSample.i : legI;
    // Zeroing sits after the route mux, so it works on both sources
    assign srcQ = qZero ? {FIR_W{1'b0}} : (firRouteSel ? firSample.q : legQ);

    // ==========================================================
    // Pre-rotation into the right half-plane
    logic signed [DP_W-1:0] extI;     // Sign-extended I
    logic signed [DP_W-1:0] extQ;     // Sign-extended Q
    logic signed [DP_W-1:0] startX;   // Starting x after fold
    logic signed [DP_W-1:0] startY;   // Starting y after fold
    logic [PACC_W-1:0]      startZ;   // Starting angle after fold

    assign extI = DP_W'(signed'(srcI));
    assign extQ = DP_W'(signed'(srcQ));
    // Folding a left-half vector by 180 degrees keeps the iterations convergent
    assign startX = extI[DP_W-1] ? -extI : extI;
    assign startY = extI[DP_W-1] ? -extQ : extQ;
    assign startZ = extI[DP_W-1] ? PH_HALF : {PACC_W{1'b0}};

    // ==========================================================
    // Iteration state
    cpc_state_type          state_reg;
    cpc_state_type          state_next;
    logic signed [DP_W-1:0] x_reg;        // Vector x
    logic signed [DP_W-1:0] y_reg;        // Vector y
    logic [PACC_W-1:0]      z_reg;        // Accumulated angle, one turn is 2^24
    logic [CNT_W-1:0]       iter_reg;     // Current iteration index
    logic signed [DP_W-1:0] x_next;
    logic signed [DP_W-1:0] y_next;
    logic [PACC_W-1:0]      z_next;
    logic                   lastIter;     // Final micro-rotation this cycle
    logic                   latchNow;     // Results latched this cycle

    logic signed [DP_W-1:0] xShift;       // x scaled by 2^-k
    logic signed [DP_W-1:0] yShift;       // y scaled by 2^-k

    assign xShift = x_reg >>> iter_reg;
    assign yShift = y_reg >>> iter_reg;
    // Rotate toward the x axis; sign of y picks the direction
    assign x_next = y_reg[DP_W-1] ? x_reg - yShift : x_reg + yShift;
    assign y_next = y_reg[DP_W-1] ? y_reg + xShift : y_reg - xShift;
    assign z_next = y_reg[DP_W-1] ? z_reg - cpc_atan(iter_reg) : z_reg + cpc_atan(iter_reg);

    assign lastIter = (state_reg == CPC_RUN) && (iter_reg == ITER_LAST);
    // A new sample mid-run cuts the computation short and keeps what exists
    assign latchNow = lastIter || ((state_reg == CPC_RUN) && sampleStrobe);

    // Next state: a strobe always starts a new run
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            CPC_IDLE: begin
                if (sampleStrobe) begin
                    state_next = CPC_RUN;
                end
            end
            CPC_RUN: begin
                if (sampleStrobe) begin
                    state_next = CPC_RUN;
                end else if (lastIter) begin
                    state_next = CPC_IDLE;
                end
            end
            default: state_next = CPC_IDLE;
        endcase
    end

    // ==========================================================
    // Result formatting
    logic signed [DP_W-1:0] curX;     // Magnitude source at latch time
    logic [PACC_W-1:0]      curZ;     // Phase source at latch time
    logic [MAG_W-1:0]       magWord;  // Formatted magnitude
    logic [PH_W-1:0]        phFull;   // Truncated 18-bit phase

    // On the last iteration the just-computed step is included
    assign curX = lastIter ? x_next : x_reg;
    assign curZ = lastIter ? z_next : z_reg;
    // Gain 1.64676 is inherent to the rotations and is not removed
    assign magWord = {1'b0, curX[MAG_LSB_POS+MAG_W-2:MAG_LSB_POS]};
    // Truncation, not rounding: keeps wrap at 360 degrees exact
    assign phFull = curZ[PACC_W-1:PACC_W-PH_W];

    // ==========================================================
    // State registers
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_reg <= CPC_IDLE;
            x_reg     <= '0;
            y_reg     <= '0;
            z_reg     <= '0;
            iter_reg  <= '0;
        end else if (clockEnable) begin
            state_reg <= state_next;
            if (sampleStrobe) begin
                x_reg    <= startX;
                y_reg    <= startY;
                z_reg    <= startZ;
                iter_reg <= '0;
            end else if (state_reg == CPC_RUN) begin
                x_reg    <= x_next;
                y_reg    <= y_next;
                z_reg    <= z_next;
                iter_reg <= iter_reg + 5'h01;
            end
        end
    end

    // Holding register for discriminator and formatter
    always_ff @(posedge clock) begin
        if (!rstn) begin
            result      <= '0;
            resultReady <= 1'b0;
        end else if (clockEnable) begin
            resultReady <= latchNow;
            if (latchNow) begin
                result.mag       <= magWord;
                result.phase     <= phFull[PH_W-1:PH_W-PHO_W];
                result.phaseFull <= phFull;
            end
        end
    end

    // ==========================================================
    // Checks
    logic [CNT_W-1:0] runLen_reg;     // Cycles since last strobe, helper only

    always_ff @(posedge clock) begin
        if (!rstn) begin
            runLen_reg <= '0;
        end else if (clockEnable) begin
            runLen_reg <= sampleStrobe ? 5'h00 : (runLen_reg + 5'h01);
        end
    end

    sequence seqStart;
        clockEnable && sampleStrobe;
    endsequence

    sequence seqQuiet16;
        (clockEnable && !sampleStrobe) [*8] ##1 (clockEnable && !sampleStrobe) [*8];
    endsequence

    AST_FULL_RUN: assert property (@(posedge clock) disable iff (!rstn)
        seqStart ##1 seqQuiet16 ##1 clockEnable |=> resultReady)
        else $error("Result not latched after seventeen iterations");

    AST_EARLY_LATCH: assert property (@(posedge clock) disable iff (!rstn)
        (clockEnable && sampleStrobe && state_reg == CPC_RUN) |=> resultReady)
        else $error("Early sample did not latch partial result");

    AST_MAG_MSB: assert property (@(posedge clock) disable iff (!rstn)
        result.mag[MAG_MSB] == 1'b0)
        else $error("Magnitude MSB is not zero");

    AST_PHASE_SLICE: assert property (@(posedge clock) disable iff (!rstn)
        result.phase == result.phaseFull[PH_W-1:PH_W-PHO_W])
        else $error("Formatter phase is not the full phase MSBs");

    // A frozen cycle holds the strobe, so only enabled cycles are judged
    AST_STROBE_PULSE: assert property (@(posedge clock) disable iff (!rstn)
        (resultReady && $past(clockEnable)) |-> $past(latchNow))
        else $error("Output strobe without a latch");

    AST_STROBE_SEL: assert property (@(posedge clock) disable iff (!rstn)
        (clockEnable && resamplerBypass && gainReady && state_reg == CPC_IDLE)
        |=> state_reg == CPC_RUN && iter_reg == 5'h00)
        else $error("Gain strobe did not start a run in bypass");

    AST_Q_ZERO: assert property (@(posedge clock) disable iff (!rstn)
        (clockEnable && sampleStrobe && qZero && !srcI[FIR_W-1])
        |=> y_reg == '0 && z_reg == '0)
        else $error("Q input not zeroed");

    AST_NO_LATE_LATCH: assert property (@(posedge clock) disable iff (!rstn)
        (runLen_reg > 5'h11) |-> !resultReady)
        else $error("Latch after run finished");

    // ==========================================================
    // Freeze, hold, reset, bound, idle, routing, strobe select and fold checks
    // Low enable stalls everything; partner logic relies on this to pause us
    sequence seqFrozen;
        !clockEnable;
    endsequence

    // A capture of a non-negative I on the direct FIR route
    sequence seqFirTake;
        clockEnable && sampleStrobe && firRouteSel && !qZero && !firSample.i[FIR_W-1];
    endsequence

    // A capture of a non-negative I on the legacy route
    sequence seqLegTake;
        clockEnable && sampleStrobe && !firRouteSel && !qZero && !legacySample.i[LEG_W-1];
    endsequence

    // Iteration state must not move while frozen
    AST_FREEZE_STATE: assert property (@(posedge clock) disable iff (!rstn)
        seqFrozen |=> $stable(state_reg) && $stable(iter_reg) && $stable(z_reg))
        else $error("State moved while clock enable was low");

    // Outputs must not move while frozen
    AST_FREEZE_OUT: assert property (@(posedge clock) disable iff (!rstn)
        seqFrozen |=> $stable(result) && $stable(resultReady))
        else $error("Outputs moved while clock enable was low");

    // Results stand until the next latch
    AST_RESULT_HOLD: assert property (@(posedge clock) disable iff (!rstn)
        (clockEnable && !latchNow) |=> $stable(result))
        else $error("Result changed without a latch");

    // Synchronous reset clears results and returns to idle
    AST_RESET_CLEAR: assert property (@(posedge clock)
        !rstn |=> (result == '0) && !resultReady && (state_reg == CPC_IDLE))
        else $error("Reset did not clear the converter");

    // The index never runs past the last micro-rotation
    AST_ITER_BOUND: assert property (@(posedge clock) disable iff (!rstn)
        (state_reg == CPC_RUN) |-> (iter_reg <= ITER_LAST))
        else $error("Iteration index beyond the last step");

    // Idle never latches: a latch needs a run in progress
    AST_IDLE_QUIET: assert property (@(posedge clock) disable iff (!rstn)
        (clockEnable && state_reg == CPC_IDLE) |=> !resultReady)
        else $error("Latch while idle");

    // The direct route takes all 26 bits unscaled
    AST_ROUTE_FIR: assert property (@(posedge clock) disable iff (!rstn)
        seqFirTake |=> (x_reg == DP_W'(signed'($past(firSample.i))))
                    && (y_reg == DP_W'(signed'($past(firSample.q)))))
        else $error("Direct FIR sample not captured whole");

    // The legacy route lands on the FIR scale, 8 bits up
    AST_ROUTE_LEG: assert property (@(posedge clock) disable iff (!rstn)
        seqLegTake |=> (x_reg == DP_W'(signed'({$past(legacySample.i), 8'h00})))
                    && (y_reg == DP_W'(signed'({$past(legacySample.q), 8'h00}))))
        else $error("Legacy sample not captured at FIR scale");

    // With the resampler in the path its strobe starts the run
    AST_RESAMP_SEL: assert property (@(posedge clock) disable iff (!rstn)
        (clockEnable && !resamplerBypass && resamplerReady)
        |=> (state_reg == CPC_RUN) && (iter_reg == 5'h00))
        else $error("Resampler strobe did not start a run");

    // An unselected strobe must not start anything
    AST_STROBE_IGNORE: assert property (@(posedge clock) disable iff (!rstn)
        (clockEnable && resamplerBypass && !gainReady && state_reg == CPC_IDLE)
        |=> (state_reg == CPC_IDLE))
        else $error("Unselected strobe started a run");

    // A left-half vector starts half a turn round
    AST_FOLD: assert property (@(posedge clock) disable iff (!rstn)
        (clockEnable && sampleStrobe && srcI[FIR_W-1]) |=> (z_reg == PH_HALF))
        else $error("Left-half vector not folded by half a turn");

endmodule

/* File: design/cpc_pkg.sv */
package cpc_pkg;

    // ==========================================================
    // Widths
    localparam int LEG_W   = 18;           // Legacy I/Q sample width
    localparam int FIR_W   = 26;           // Direct FIR sample width
    localparam int DP_W    = 30;           // Internal datapath width with guard bits
    localparam int PH_W    = 18;           // Full phase width
    localparam int PHO_W   = 16;           // Formatter phase width
    localparam int MAG_W   = 16;           // Magnitude width
    localparam int ITER_N  = 17;           // Iterations for full precision
    localparam int CNT_W   = 5;            // Iteration counter width
    localparam int PACC_W  = 24;           // Internal phase accumulator width

    // ==========================================================
    // Field positions and constants
    localparam int MAG_MSB      = 15;                  // Always reads zero
    localparam int LEG_SHIFT    = FIR_W - LEG_W;       // Align legacy samples to FIR scale
    localparam int MAG_LSB_POS  = 12;                  // Datapath bit taken as magnitude LSB
    localparam logic [CNT_W-1:0] ITER_LAST = 5'h10;    // Index of the last iteration
    localparam logic [PACC_W-1:0] PH_HALF  = 24'h800000; // 180 degrees

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [LEG_W-1:0] i;
        logic [LEG_W-1:0] q;
    } cpc_leg_type;

    typedef struct packed {
        logic [FIR_W-1:0] i;
        logic [FIR_W-1:0] q;
    } cpc_fir_type;

    typedef struct packed {
        logic [MAG_W-1:0] mag;
        logic [PHO_W-1:0] phase;
        logic [PH_W-1:0]  phaseFull;
    } cpc_res_type;

    typedef enum logic [1:0] {
        CPC_IDLE = 2'b01,
        CPC_RUN  = 2'b10
    } cpc_state_type;

    // Arctangent of 2^-k as a fraction of a full turn, 24 bits
    function automatic logic [PACC_W-1:0] cpc_atan(input logic [CNT_W-1:0] k);
        logic [PACC_W-1:0] v;
        v = 24'h000000;
        unique case (k)
            5'h00: v = 24'h200000;
            5'h01: v = 24'h12E405;
            5'h02: v = 24'h09FB38;
            5'h03: v = 24'h051112;
            5'h04: v = 24'h028B0D;
            5'h05: v = 24'h0145D8;
            5'h06: v = 24'h00A2F6;
            5'h07: v = 24'h00517C;
            5'h08: v = 24'h0028BE;
            5'h09: v = 24'h00145F;
            5'h0A: v = 24'h000A30;
            5'h0B: v = 24'h000518;
            5'h0C: v = 24'h00028C;
            5'h0D: v = 24'h000146;
            5'h0E: v = 24'h0000A3;
            5'h0F: v = 24'h000051;
            5'h10: v = 24'h000029;
            default: v = 24'h000000;
        endcase
        return v;
    endfunction

endpackage

/* File: tb/cpc_src_model.sv */
`timescale 1ns/10ps
// ==========================================
// Upstream datapath: sample buses and strobes
module cpc_src_model
    import cpc_pkg::*;
(
    input  wire logic   clock,
    output cpc_leg_type legacySample,
    output cpc_fir_type firSample,
    output logic        gainReady,
    output logic        resamplerReady
);
    integer      seed    = 5630;   // Fixed seed for idle noise
    logic        pend    = 1'b0;   // A sample is on offer
    logic        useGain = 1'b1;   // Which strobe carries it
    cpc_leg_type pendL;            // Offered legacy sample
    cpc_fir_type pendF;            // Offered FIR sample
    cpc_leg_type noiseL  = '0;     // Idle legacy bus pattern
    cpc_fir_type noiseF  = '0;     // Idle FIR bus pattern
    // Idle buses change every cycle, so a capture off the strobe shows up
    always @(negedge clock) begin
        noiseL <= {18'($random(seed)), 18'($random(seed))};
        noiseF <= {26'($random(seed)), 26'($random(seed))};
    end
    assign legacySample   = pend ? pendL : noiseL;
    assign firSample      = pend ? pendF : noiseF;
    assign gainReady      = pend & useGain;
    assign resamplerReady = pend & ~useGain;
    // Offer one sample at a falling edge; released after the sampling edge
    task automatic give(input cpc_leg_type l, input cpc_fir_type f, input logic g,
                        input int gap);
        pendL = l;
        pendF = f;
        useGain = g;
        pend = 1'b1;
        @(negedge clock);
        // Spacing 1 keeps the strobe up for the next sample
        if (gap > 1) begin
            pend = 1'b0;
            repeat (gap - 1) @(negedge clock);
        end
    endtask
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmpCount++; if ((e) !== (g)) begin fails++; \
    $display("BAD %s exp %0d got %0d", nm, e, g); end end
module testbench
    import cpc_pkg::*;
;
    typedef struct { int due; int n; real ph; real mg; } cpc_note_type;
    logic         clock = 1'b0;        // 25 MHz
    logic         rstn = 1'b0;         // Synchronous, active low
    logic         clockEnable = 1'b1;  // High except for the hold cycles frozen mid-run
    logic         resamplerBypass = 1'b1;
    logic         firRouteSel = 1'b0;
    logic         qZero = 1'b0;
    cpc_leg_type  legacySample, l;
    cpc_fir_type  firSample, f;
    logic         gainReady, resamplerReady, resultReady;
    cpc_res_type  result;
    cpc_note_type notes[$];            // Expected results, oldest first
    int           cyc = 0, fails = 0, cmpCount = 0;
    integer       seed = 5630;
    int           hold = 0;            // Frozen cycles inserted mid-run
    int           gaps[6] = '{1, 1, 2, 6, 16, 20};

    // ==========================================
    // Clock, cycle count and hang guard
    initial forever #20 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 1500) begin
            fails++;
            conclude();
        end
    end

    cpc_src_model cpc_src_model_i (.clock(clock), .legacySample(legacySample),
        .firSample(firSample), .gainReady(gainReady), .resamplerReady(resamplerReady));
    cpc_converter cpc_converter_i (.clock(clock), .rstn(rstn), .clockEnable(clockEnable),
        .legacySample(legacySample), .firSample(firSample), .gainReady(gainReady),
        .resamplerReady(resamplerReady), .resamplerBypass(resamplerBypass),
        .firRouteSel(firRouteSel), .qZero(qZero), .result(result), .resultReady(resultReady));

    // ==========================================
    // Helpers
    // Seen value if within tolerance (modulo span), else the ideal value
    function automatic int near(input logic [17:0] g, input real e, input real tol,
                                input int span);
        real d;
        d = g - e;
        if (span > 0 && d > span / 2) d -= span;
        if (span > 0 && d < -span / 2) d += span;
        return (d <= tol && d >= -tol) ? int'(g) : $rtoi(e);
    endfunction
    // Phase error roughly halves per iteration; loose below six
    function automatic real tolFor(input int n);
        return (n >= 17) ? 4.0 : 4.0 + 7.0 * (2.0 ** (6 - n)) * 262144.0 / 360.0;
    endfunction
    // Note the ideal result, then offer the sample
    task automatic send(input logic g, input int gap, input bit keep);
        cpc_note_type t;
        real vi, vq;
        vi = firRouteSel ? $signed(f.i) : $signed(l.i) * 256.0;
        vq = qZero ? 0.0 : (firRouteSel ? $signed(f.q) : $signed(l.q) * 256.0);
        t.n = (gap < 17) ? gap - 1 : 17;
        t.due = cyc + 1 + ((gap < 17) ? gap : 17) + hold;
        t.ph = $atan2(vq, vi) / 6.283185307179586 * 262144.0;
        if (t.ph < 0) t.ph += 262144.0;
        t.mg = 1.64676 * $sqrt(vi * vi + vq * vq) / 4096.0;
        if (keep) notes.push_back(t);
        fork
            cpc_src_model_i.give(l, f, g, gap);
            if (hold > 0) begin
                repeat (4) @(negedge clock);
                clockEnable = 1'b0;
                repeat (hold) @(negedge clock);
                clockEnable = 1'b1;
            end
        join
    endtask
    task automatic pick();
        l.i = 18'($random(seed));
        l.q = 18'($random(seed));
        f.i = 26'($random(seed));
        f.q = 26'($random(seed));
    endtask
    task automatic conclude();
        if (fails == 0 && cmpCount > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ==========================================
    // Result watcher: every strobe must match the oldest note
    always @(negedge clock) begin
        cpc_note_type t;
        if (rstn && resultReady === 1'b1) begin
            if (notes.size() == 0) begin
                `CHK("spurious", 0, 1)
            end else begin
                t = notes.pop_front();
                `CHK("cycle", t.due, cyc)
                `CHK("magTop", 1'b0, result.mag[MAG_MSB])
                `CHK("phaseFull", near(result.phaseFull, t.ph, tolFor(t.n), 262144), result.phaseFull)
                `CHK("phase", near(result.phase, t.ph / 4, tolFor(t.n) / 4 + 1, 65536), result.phase)
                if (t.n >= 12) `CHK("mag", near(result.mag, t.mg, 8, 0), result.mag)
            end
        end
    end

    // ==========================================
    // Stimulus
    initial begin
        repeat (2) @(negedge clock);
        rstn = 1'b1;
        // Full precision on both routings, both strobe sources, Q zeroed too
        for (int k = 0; k < 24; k++) begin
            pick();
            firRouteSel = k[0];
            qZero = (k % 6 == 5);
            resamplerBypass = k[1];
            send(k[1], 20, 1'b1);
        end
        // A frozen stretch mid-run delays the full result by its length
        pick();
        hold = 3;
        send(resamplerBypass, 24, 1'b1);
        hold = 0;
        // Early arrivals latch partial results, back to back included
        foreach (gaps[j]) begin
            pick();
            send(resamplerBypass, gaps[j], 1'b1);
        end
        // A strobe on the unselected source starts nothing
        pick();
        send(~resamplerBypass, 20, 1'b0);
        conclude();
    end
endmodule
